// [shared/idrr_pkg.sv]
// Shared constants and types for the display memory readback slave
package idrr_pkg;

  // ****************************************
  // Memory and address layout
  // ****************************************
  localparam int MEM_DEPTH = 80;
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 7'h4F;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ****************************************
  // Serial framing
  // ****************************************
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1D;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CTRL_CONT_BIT = 7;
  localparam int CTRL_SEL_BIT = 6;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [6:0] INS_HOME_HI = 7'h01;
  localparam logic [5:0] INS_ENTRY_HI = 6'h01;
  localparam int INS_SETADDR_BIT = 7;

  typedef enum logic [2:0] {
    IDRR_IDLE,
    IDRR_ADDR,
    IDRR_ADDR_ACK,
    IDRR_WR_BYTE,
    IDRR_WR_ACK,
    IDRR_RD_BYTE,
    IDRR_RD_ACK
  } idrr_state_t;

  // Bus events seen on one system clock cycle
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } idrr_bus_ev_t;

endpackage : idrr_pkg

// [src/idrr_bus_edges.sv]
// Start, stop and clock edge detection on the two-wire bus
module idrr_bus_edges
  import idrr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Events
  output idrr_bus_ev_t ev_out
);

  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  // Data moving while the clock is high marks frame limits
  always_comb begin
    ev_out.start = scl_q_r & scl_in & sda_q_r & ~sda_in;
    ev_out.stop = scl_q_r & scl_in & ~sda_q_r & sda_in;
    ev_out.scl_rise = ~scl_q_r & scl_in;
    ev_out.scl_fall = scl_q_r & ~scl_in;
    ev_out.sda = sda_in;
  end

endmodule : idrr_bus_edges

// [src/idrr_top.sv]
// Two-wire slave with display text memory readback
// What this block does
// - Return-home clears address counter and display shift; memory untouched.
// - Return-home leaves the read buffer unchanged.
// - Read-direction address copies read buffer (data select) or address counter (instruction select) into shifter during its acknowledge.
// - After data-select control byte, reads return display text memory.
// - Read byte goes out MSB first over eight clock pulses.
// - Master acknowledge loads the byte at the next memory address (data select) or that address itself (instruction select) into the shifter.
// - Missing acknowledge: nothing loaded, nothing advanced.
module idrr_top
  import idrr_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_bit0_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Display state
  output logic [ADDR_W-1:0] addr_counter_out,
  output logic [ADDR_W-1:0] display_shift_out,
  output logic [7:0] read_buffer_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic up);
    logic [ADDR_W-1:0] r;
    r = a;
    if (up) begin
      r = (a >= ADDR_LAST) ? ADDR_RST : a + 7'h01;
    end else begin
      r = (a == ADDR_RST) ? ADDR_LAST : a - 7'h01;
    end
    return r;
  endfunction : step_addr

  // ****************************************
  // State
  // ****************************************
  idrr_bus_ev_t ev;
  idrr_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic ctrl_exp_r;
  logic cont_r;
  logic select_data_r;
  logic ack_r;
  logic inc_r;
  logic shift_en_r;
  logic sda_oe_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] disp_shift_r;
  logic [7:0] read_buffer_r;
  logic [7:0] mem [0:DEPTH-1];
  logic [ADDR_W-1:0] next_addr;
  logic [7:0] next_data;
  logic [7:0] byte_in;
  logic byte_end;
  logic wr_data_done;
  logic rd_acked;
  logic addr_match;

  idrr_bus_edges u_edges (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev_out(ev)
  );

  always_comb begin
    byte_in = rx_r;
    byte_end = ev.scl_fall && (bit_cnt_r == BITS_PER_BYTE);
    wr_data_done = (state_r == IDRR_WR_BYTE) && byte_end && !ctrl_exp_r;
    rd_acked = (state_r == IDRR_RD_ACK) && ev.scl_rise && !ev.sda;
    addr_match = (rx_r[7:1] == {SLAVE_ADDR_HI, slave_addr_bit0_in});
    next_addr = step_addr(addr_r, inc_r);
    next_data = mem[next_addr];
  end

  // ****************************************
  // Bit and byte sequencing
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= IDRR_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= BYTE_RST;
      tx_r <= BYTE_RST;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (ev.start) begin
      // Repeated start keeps the selected data path
      state_r <= IDRR_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (ev.stop) begin
      state_r <= IDRR_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      if (ev.scl_rise && (state_r == IDRR_ADDR || state_r == IDRR_WR_BYTE || state_r == IDRR_RD_BYTE)) begin
        rx_r <= {rx_r[6:0], ev.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      case (state_r)
        IDRR_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        IDRR_ADDR: begin
          if (byte_end) begin
            if (addr_match) begin
              state_r <= IDRR_ADDR_ACK;
              sda_oe_r <= 1'b1;
              rw_r <= rx_r[0];
              // Buffer loaded into shifter at address acknowledge
              // Data select returns memory, else status with busy low
              tx_r <= select_data_r ? read_buffer_r : {1'b0, addr_r};
            end else begin
              // Not our address: stay off the bus until the next start
              state_r <= IDRR_IDLE;
            end
          end
        end
        IDRR_ADDR_ACK: begin
          if (ev.scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              state_r <= IDRR_RD_BYTE;
              sda_oe_r <= ~tx_r[7];
            end else begin
              state_r <= IDRR_WR_BYTE;
              sda_oe_r <= 1'b0;
            end
          end
        end
        IDRR_WR_BYTE: begin
          if (byte_end) begin
            state_r <= IDRR_WR_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        IDRR_WR_ACK: begin
          if (ev.scl_fall) begin
            state_r <= IDRR_WR_BYTE;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
          end
        end
        IDRR_RD_BYTE: begin
          // Eight bits, MSB first, changed on clock fall
          if (byte_end) begin
            state_r <= IDRR_RD_ACK;
            sda_oe_r <= 1'b0;
          end else if (ev.scl_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        IDRR_RD_ACK: begin
          if (ev.scl_rise) begin
            ack_r <= !ev.sda;
            // Next memory byte, or next address under instruction select, loaded on master acknowledge
            if (!ev.sda) begin
              tx_r <= select_data_r ? next_data : {1'b0, next_addr};
            end
          end
          if (ev.scl_fall) begin
            bit_cnt_r <= 4'h0;
            // Without acknowledge, wait for the stop
            if (ack_r) begin
              state_r <= IDRR_RD_BYTE;
              sda_oe_r <= ~tx_r[7];
            end else begin
              state_r <= IDRR_IDLE;
            end
          end
        end
        default: begin
          state_r <= IDRR_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Control byte tracking
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_exp_r <= 1'b1;
      cont_r <= 1'b0;
      select_data_r <= 1'b1;
    end else if (state_r == IDRR_ADDR_ACK && ev.scl_fall && !rw_r) begin
      ctrl_exp_r <= 1'b1;
    end else if (state_r == IDRR_WR_BYTE && byte_end) begin
      if (ctrl_exp_r) begin
        cont_r <= byte_in[CTRL_CONT_BIT];
        select_data_r <= byte_in[CTRL_SEL_BIT];
        ctrl_exp_r <= 1'b0;
      end else begin
        // Continuation set means another control byte follows
        ctrl_exp_r <= cont_r;
      end
    end
  end

  // ****************************************
  // Address counter, shift and read buffer
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      addr_r <= ADDR_RST;
      disp_shift_r <= ADDR_RST;
      read_buffer_r <= BYTE_RST;
      inc_r <= 1'b1;
      shift_en_r <= 1'b0;
    end else if (wr_data_done && select_data_r) begin
      addr_r <= next_addr;
      if (shift_en_r) begin
        disp_shift_r <= step_addr(disp_shift_r, !inc_r);
      end
    end else if (wr_data_done) begin
      if (byte_in[INS_SETADDR_BIT]) begin
        addr_r <= byte_in[ADDR_W-1:0];
        read_buffer_r <= mem[byte_in[ADDR_W-1:0]];
      end else if (byte_in[7:1] == INS_HOME_HI) begin
        // Home: counter and shift to zero, memory kept
        // Read buffer deliberately not touched here
        addr_r <= ADDR_RST;
        disp_shift_r <= ADDR_RST;
      end else if (byte_in[7:2] == INS_ENTRY_HI) begin
        inc_r <= byte_in[1];
        shift_en_r <= byte_in[0];
      end
    end else if (rd_acked && select_data_r) begin
      // Acknowledged read steps address per entry mode
      addr_r <= next_addr;
      read_buffer_r <= next_data;
    end
    // Missing acknowledge leaves all of this untouched
  end

  // ****************************************
  // Display text memory
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (wr_data_done && select_data_r) begin
      mem[addr_r] <= byte_in;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sda_out <= 1'b0;
      addr_counter_out <= ADDR_RST;
      display_shift_out <= ADDR_RST;
      read_buffer_out <= BYTE_RST;
    end else begin
      sda_out <= 1'b0;
      addr_counter_out <= addr_r;
      display_shift_out <= disp_shift_r;
      read_buffer_out <= read_buffer_r;
    end
  end

  assign sda_oe_out = sda_oe_r;

endmodule : idrr_top

// [verif/idrr_readback_monitor.sv]
// Port checker for the display memory readback slave
module idrr_readback_monitor
  import idrr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_bit0_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Display state
  input wire logic [ADDR_W-1:0] addr_counter_out,
  input wire logic [ADDR_W-1:0] display_shift_out,
  input wire logic [7:0] read_buffer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // Data may only move while the clock is high for start and stop
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  AST_SDA_LOW: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_OE_AFTER_FALL: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("drive started outside clock low");
  AST_OE_STEADY_HIGH: assert property ($rose(scl_in) |=> $stable(sda_oe_out) [*3])
    else $error("drive changed while clock high");
  AST_OE_FALL_LOW: assert property ($fell(sda_oe_out) |-> !scl_in)
    else $error("drive released while clock high");
  AST_START_RELEASE: assert property (s_start |-> ##[1:3] !sda_oe_out)
    else $error("drive held after start");
  AST_STOP_RELEASE: assert property (s_stop |-> ##[1:3] !sda_oe_out)
    else $error("drive held after stop");
  AST_ADDR_RANGE: assert property (addr_counter_out <= ADDR_LAST)
    else $error("address counter out of range");
  AST_RESET_CLEARS: assert property ($fell(rst_in) |-> addr_counter_out == ADDR_RST
    && display_shift_out == ADDR_RST && !sda_oe_out)
    else $error("state not cleared by reset");
endmodule : idrr_readback_monitor

bind idrr_top idrr_readback_monitor u_mon (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .slave_addr_bit0_in(slave_addr_bit0_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .addr_counter_out(addr_counter_out), .display_shift_out(display_shift_out),
  .read_buffer_out(read_buffer_out));

// [verif/idrr_master_model.sv]
// Behavioural two-wire bus master
module idrr_master_model (
  // Clock
  input wire logic clk_sys_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: clock high, data released
  initial begin
    scl_out <= 1'b1;
    sda_oe_out <= 1'b0;
  end
  // Four cycles per phase keeps above the three-cycle minimum
  task automatic tick();
    repeat (4) @(posedge clk_sys_in);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out <= ~b;
    tick();
    scl_out <= 1'b1;
    tick();
    r = sda_in;
    scl_out <= 1'b0;
    tick();
  endtask : bit_io
  task automatic start();
    sda_oe_out <= 1'b0;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_oe_out <= 1'b1;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_oe_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_oe_out <= 1'b0;
    tick();
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : rbyte
endmodule : idrr_master_model

// [verif/idrr_top_bench.sv]
// Testbench for the display memory readback slave
module idrr_top_bench
  import idrr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic addr_strap = 1'b0;
  logic scl;
  logic m_oe;
  logic sda_out;
  logic sda_oe_out;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] shift_q;
  logic [7:0] rb_q;
  // Pull-up wire: low when either party pulls
  wire logic sda = ~(m_oe | sda_oe_out);
  int num_errors = 0;
  int total_checks = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  idrr_top #(.DEPTH(MEM_DEPTH)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .slave_addr_bit0_in(addr_strap), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_counter_out(addr_q),
    .display_shift_out(shift_q), .read_buffer_out(rb_q));
  idrr_master_model u_master (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic send(input logic [7:0] q[$]);
    logic a;
    u_master.start();
    foreach (q[i]) u_master.wbyte(q[i], a);
  endtask : send
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic wrong_address();
    logic a;
    u_master.start();
    u_master.wbyte(8'h76, a);
    check8({7'h00, a}, 8'h00);
    u_master.stop();
    // Strap the low address bit high: the same byte now matches
    addr_strap <= 1'b1;
    u_master.start();
    u_master.wbyte(8'h76, a);
    check8({7'h00, a}, 8'h01);
    u_master.stop();
    addr_strap <= 1'b0;
  endtask : wrong_address
  task automatic fill_memory();
    // Entry mode with display shift, then three data bytes
    send({8'h74, 8'h80, 8'h07, 8'h40, 8'h50, 8'h48, 8'h49});
    check8({1'b0, addr_q}, 8'h03);
  endtask : fill_memory
  task automatic return_home();
    // Set address 2 first so the buffer holds a known nonzero byte
    send({8'h74, 8'h80, 8'h82, 8'h80, 8'h02, 8'h40});
    check8({1'b0, addr_q}, 8'h00);
    check8({1'b0, shift_q}, 8'h00);
    check8(rb_q, 8'h49);
  endtask : return_home
  task automatic read_back();
    logic a;
    logic [7:0] d;
    u_master.start();
    u_master.wbyte(8'h75, a);
    check8({7'h00, a}, 8'h01);
    u_master.rbyte(1'b1, d);
    check8(d, 8'h49);
    u_master.rbyte(1'b1, d);
    check8(d, 8'h48);
    check8({1'b0, addr_q}, 8'h02);
    u_master.rbyte(1'b0, d);
    check8(d, 8'h49);
    u_master.stop();
    check8({1'b0, addr_q}, 8'h02);
    check8(rb_q, 8'h49);
    check8({7'h00, sda_oe_out}, 8'h00);
  endtask : read_back
  task automatic status_read();
    logic a;
    logic [7:0] d;
    // Instruction select: a read returns the address counter
    send({8'h74, 8'h00});
    u_master.start();
    u_master.wbyte(8'h75, a);
    check8({7'h00, a}, 8'h01);
    u_master.rbyte(1'b0, d);
    check8(d, 8'h02);
    u_master.stop();
    check8({1'b0, addr_q}, 8'h02);
  endtask : status_read
  task automatic mid_reset();
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check8({1'b0, addr_q}, {1'b0, ADDR_RST});
    check8(rb_q, BYTE_RST);
    check8({1'b0, shift_q}, {1'b0, ADDR_RST});
  endtask : mid_reset
  // Hang guard counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    wrong_address();
    fill_memory();
    return_home();
    read_back();
    status_read();
    mid_reset();
    complete_run();
  end
endmodule : idrr_top_bench
